/* File: design/spm_defs.vh */
`ifndef SPM_DEFS_VH
`define SPM_DEFS_VH

// global power mode field encodings
`define SPM_MODE_W          2
`define SPM_MODE_NORMAL     2'h0
`define SPM_MODE_ENERGY     2'h1
`define SPM_MODE_SOFT_PD    2'h2
`define SPM_MODE_SAVING     2'h3
`define SPM_MODE_RST_VAL    2'h0

// port count and sleep delay field width
`define SPM_NUM_PORTS       5
`define SPM_SLEEP_W         8

// reference clock period and derived timing
`define SPM_CLK_PERIOD_NS   5
`define SPM_SLEEP_TICK_NS   1000000
`define SPM_SLEEP_TICK_CYC  (`SPM_SLEEP_TICK_NS / `SPM_CLK_PERIOD_NS)
`define SPM_INT_RST_NS      80
`define SPM_INT_RST_CYC     ((`SPM_INT_RST_NS + `SPM_CLK_PERIOD_NS - 1) / `SPM_CLK_PERIOD_NS)

`endif

/* File: design/spm_sync3.v */
`timescale 1ns/1ps

module spm_sync3
#(
   parameter WIDTH   = 1,
   parameter RST_VAL = 1'b0
)
(
   // clock and reset
   input  wire             i_clk,
   input  wire             i_srst,
   // asynchronous pins in, filtered levels out
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1)
      begin : g_bit
         reg ff1_r;
         reg ff2_r;
         reg ff3_r;
         reg out_r;
         // ff1 feeds ff2 only; the level moves once ff2 and ff3 agree
         always @(posedge i_clk)
         begin
            if (i_srst)
            begin
               ff1_r <= RST_VAL;
               ff2_r <= RST_VAL;
               ff3_r <= RST_VAL;
               out_r <= RST_VAL;
            end
            else
            begin
               ff1_r <= i_async[g];
               ff2_r <= ff1_r;
               ff3_r <= ff2_r;
               if (ff2_r == ff3_r)
               begin
                  out_r <= ff3_r;
               end
            end
         end
         assign o_sync[g] = out_r;
      end
   endgenerate

endmodule // spm_sync3

/* File: design/spm_power_ctrl.v */
// Behaviour
// - power-down pin low turns everything off
// - pin release triggers internal reset first
// - two-bit mode: normal, energy, soft-down, saving
// - per-port bit powers down that PHY
// - each mode gates PLL, PHY, MAC, host
// - reset leaves normal mode, all but energy detect enabled
// - host access wakes soft-down with reset
// - energy mode sleeps after idle delay
`timescale 1ns/1ps
`include "spm_defs.vh"

module spm_power_ctrl
#(
   parameter NUM_PORTS      = `SPM_NUM_PORTS,
   parameter SLEEP_TICK_CYC = `SPM_SLEEP_TICK_CYC,
   parameter INT_RST_CYC    = `SPM_INT_RST_CYC
)
(
   // clock and reset
   input  wire                   I_REF_CLK,
   input  wire                   I_SRST,
   // pins
   input  wire                   I_CHIP_POWER_DOWN_N,
   input  wire [NUM_PORTS-1:0]   I_CABLE_ENERGY,
   // control fields from the register side
   input  wire                   I_MODE_WR,
   input  wire [1:0]             I_MODE_WDATA,
   input  wire [NUM_PORTS-1:0]   I_PORT_PD,
   input  wire [7:0]             I_SLEEP_DELAY,
   input  wire                   I_HOST_ACCESS,
   // gating outputs
   output reg                    O_PLL_CLK_EN,
   output reg                    O_MAC_EN,
   output reg                    O_HOST_EN,
   output reg  [NUM_PORTS-1:0]   O_PHY_TX_EN,
   output reg  [NUM_PORTS-1:0]   O_PHY_RX_EN,
   output reg  [NUM_PORTS-1:0]   O_RX_ENERGY_DET_EN,
   // status
   output reg  [1:0]             O_PWR_MODE,
   output reg                    O_INT_RST,
   output reg                    O_LOW_POWER
);

   localparam [2:0] ST_RUN   = 3'h1;
   localparam [2:0] ST_HWPD  = 3'h2;
   localparam [2:0] ST_RESET = 3'h4;

   localparam [31:0] TICK_MAX = SLEEP_TICK_CYC - 1;
   // cut on purpose: the reset stretch never needs more than 16 bits
   localparam integer RST_LAST = INT_RST_CYC - 1;
   localparam [15:0]  RST_MAX  = RST_LAST[15:0];

   wire                 chip_power_down_n;
   wire [NUM_PORTS-1:0] energy;

   reg  [2:0]           state_r;
   reg  [2:0]           state_nxt;
   reg  [1:0]           mode_r;
   reg  [1:0]           mode_nxt;
   reg  [15:0]          rst_cnt_r;
   reg  [15:0]          rst_cnt_nxt;
   reg  [31:0]          tick_cnt_r;
   reg  [31:0]          tick_cnt_nxt;
   reg  [8:0]           idle_cnt_r;
   reg  [8:0]           idle_cnt_nxt;
   reg                  sleep_r;
   reg                  sleep_nxt;

   reg                  pll_nxt;
   reg                  mac_nxt;
   reg                  host_nxt;
   reg  [NUM_PORTS-1:0] tx_nxt;
   reg  [NUM_PORTS-1:0] rx_nxt;
   reg  [NUM_PORTS-1:0] edet_nxt;
   reg                  int_rst_nxt;

   wire                 any_energy = |energy;

   // pin idles high so the chip is not held down while the filter fills
   spm_sync3
   #(
      .WIDTH   (1),
      .RST_VAL (1'b1)
   )
   u_pd_sync
   (
      .i_clk   (I_REF_CLK),
      .i_srst  (I_SRST),
      .i_async (I_CHIP_POWER_DOWN_N),
      .o_sync  (chip_power_down_n)
   );

   spm_sync3
   #(
      .WIDTH   (NUM_PORTS),
      .RST_VAL (1'b0)
   )
   u_energy_sync
   (
      .i_clk   (I_REF_CLK),
      .i_srst  (I_SRST),
      .i_async (I_CABLE_ENERGY),
      .o_sync  (energy)
   );

   // sequencing and mode register
   always @*
   begin
      state_nxt    = state_r;
      mode_nxt     = mode_r;
      rst_cnt_nxt  = rst_cnt_r;
      tick_cnt_nxt = tick_cnt_r;
      idle_cnt_nxt = idle_cnt_r;
      sleep_nxt    = sleep_r;
      case (state_r)
         ST_RUN:
         begin
            if (mode_r == `SPM_MODE_SOFT_PD)
            begin
               if (I_HOST_ACCESS)
               begin
                  state_nxt   = ST_RESET;
                  mode_nxt    = `SPM_MODE_RST_VAL;
                  rst_cnt_nxt = 16'h0000;
               end
            end
            else if (I_MODE_WR && (mode_r == `SPM_MODE_NORMAL || mode_r == `SPM_MODE_SAVING))
            begin
               // host side is off in energy mode, so writes only land here
               mode_nxt = I_MODE_WDATA;
            end
         end
         ST_HWPD:
         begin
            if (chip_power_down_n)
            begin
               state_nxt   = ST_RESET;
               mode_nxt    = `SPM_MODE_RST_VAL;
               rst_cnt_nxt = 16'h0000;
            end
         end
         ST_RESET:
         begin
            mode_nxt = `SPM_MODE_RST_VAL;
            if (rst_cnt_r == RST_MAX)
            begin
               state_nxt = ST_RUN;
            end
            else
            begin
               rst_cnt_nxt = rst_cnt_r + 16'h0001;
            end
         end
         default:
         begin
            state_nxt = ST_RESET;
         end
      endcase
      if (!chip_power_down_n)
      begin
         state_nxt = ST_HWPD;
      end

      // idle timer counts sleep-delay ticks while no port sees energy
      if (state_r != ST_RUN || mode_r != `SPM_MODE_ENERGY || any_energy)
      begin
         tick_cnt_nxt = 32'h0000_0000;
         idle_cnt_nxt = 9'h000;
         sleep_nxt    = 1'b0;
      end
      else if (!sleep_r)
      begin
         if (tick_cnt_r == TICK_MAX)
         begin
            tick_cnt_nxt = 32'h0000_0000;
            idle_cnt_nxt = idle_cnt_r + 9'h001;
         end
         else
         begin
            tick_cnt_nxt = tick_cnt_r + 32'h0000_0001;
         end
         // strictly longer than the programmed delay
         if (idle_cnt_r > {1'b0, I_SLEEP_DELAY})
         begin
            sleep_nxt = 1'b1;
         end
      end
   end

   // block gating from state and mode
   always @*
   begin
      pll_nxt     = 1'b0;
      mac_nxt     = 1'b0;
      host_nxt    = 1'b0;
      tx_nxt      = {NUM_PORTS{1'b0}};
      rx_nxt      = {NUM_PORTS{1'b0}};
      edet_nxt    = {NUM_PORTS{1'b0}};
      int_rst_nxt = (state_nxt == ST_RESET);
      if (state_nxt == ST_RUN)
      begin
         case (mode_nxt)
            `SPM_MODE_NORMAL:
            begin
               pll_nxt  = 1'b1;
               mac_nxt  = 1'b1;
               host_nxt = 1'b1;
               tx_nxt   = ~I_PORT_PD;
               rx_nxt   = ~I_PORT_PD;
            end
            `SPM_MODE_SAVING:
            begin
               pll_nxt  = 1'b1;
               mac_nxt  = 1'b1;
               host_nxt = 1'b1;
               tx_nxt   = ~I_PORT_PD;
               // receiver of an idle cable is the unused part
               rx_nxt   = ~I_PORT_PD & energy;
            end
            `SPM_MODE_ENERGY:
            begin
               edet_nxt = ~I_PORT_PD;
               if (!sleep_nxt)
               begin
                  tx_nxt = ~I_PORT_PD;
                  rx_nxt = ~I_PORT_PD;
               end
            end
            default:
            begin
               pll_nxt = 1'b0;
            end
         endcase
      end
   end

   always @(posedge I_REF_CLK)
   begin
      if (I_SRST)
      begin
         state_r            <= ST_RUN;
         mode_r             <= `SPM_MODE_RST_VAL;
         rst_cnt_r          <= 16'h0000;
         tick_cnt_r         <= 32'h0000_0000;
         idle_cnt_r         <= 9'h000;
         sleep_r            <= 1'b0;
         O_PLL_CLK_EN       <= 1'b1;
         O_MAC_EN           <= 1'b1;
         O_HOST_EN          <= 1'b1;
         O_PHY_TX_EN        <= {NUM_PORTS{1'b1}};
         O_PHY_RX_EN        <= {NUM_PORTS{1'b1}};
         O_RX_ENERGY_DET_EN <= {NUM_PORTS{1'b0}};
         O_PWR_MODE         <= `SPM_MODE_RST_VAL;
         O_INT_RST          <= 1'b0;
         O_LOW_POWER        <= 1'b0;
      end
      else
      begin
         state_r            <= state_nxt;
         mode_r             <= mode_nxt;
         rst_cnt_r          <= rst_cnt_nxt;
         tick_cnt_r         <= tick_cnt_nxt;
         idle_cnt_r         <= idle_cnt_nxt;
         sleep_r            <= sleep_nxt;
         O_PLL_CLK_EN       <= pll_nxt;
         O_MAC_EN           <= mac_nxt;
         O_HOST_EN          <= host_nxt;
         O_PHY_TX_EN        <= tx_nxt;
         O_PHY_RX_EN        <= rx_nxt;
         O_RX_ENERGY_DET_EN <= edet_nxt;
         O_PWR_MODE         <= mode_nxt;
         O_INT_RST          <= int_rst_nxt;
         O_LOW_POWER        <= sleep_nxt;
      end
   end

endmodule // spm_power_ctrl

/* File: bench/spm_power_checker.sv */
`timescale 1ns/1ps
module spm_power_checker
#(
   parameter NUM_PORTS   = 5,
   parameter INT_RST_CYC = 16
)
(
   // clock and reset
   input wire                 I_REF_CLK,
   input wire                 I_SRST,
   // inputs
   input wire                 I_CHIP_POWER_DOWN_N,
   input wire                 I_MODE_WR,
   input wire [1:0]           I_MODE_WDATA,
   input wire [NUM_PORTS-1:0] I_PORT_PD,
   input wire                 I_HOST_ACCESS,
   // outputs
   input wire                 O_PLL_CLK_EN,
   input wire                 O_MAC_EN,
   input wire                 O_HOST_EN,
   input wire [NUM_PORTS-1:0] O_PHY_TX_EN,
   input wire [NUM_PORTS-1:0] O_PHY_RX_EN,
   input wire [1:0]           O_PWR_MODE,
   input wire                 O_INT_RST,
   input wire                 O_LOW_POWER
);
   reg [7:0] pin_r;
   reg [7:0] cnt_r;
   // pin steady long enough to clear the input filter
   wire      hi = I_CHIP_POWER_DOWN_N && (&pin_r);
   wire      on = O_PLL_CLK_EN && O_MAC_EN && O_HOST_EN;
   wire      nb = !(O_PLL_CLK_EN || O_MAC_EN || O_HOST_EN);
   always @(posedge I_REF_CLK)
   begin
      pin_r <= I_SRST ? 8'hFF : {pin_r[6:0], I_CHIP_POWER_DOWN_N};
      cnt_r <= O_INT_RST ? cnt_r + 8'h01 : 8'h00;
   end
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_SRST);
   a_mode_write_next: assert property (
      hi && I_MODE_WR && O_HOST_EN && !O_INT_RST |=> O_PWR_MODE == $past(I_MODE_WDATA)) else $error("mode write");
   a_soft_pd_off: assert property (
      O_PWR_MODE == 2'h2 |-> nb && O_PHY_TX_EN == 0 && O_PHY_RX_EN == 0) else $error("soft off");
   a_energy_gated: assert property (
      O_PWR_MODE == 2'h1 |-> nb) else $error("energy gating");
   a_saving_on: assert property (
      hi && O_PWR_MODE == 2'h3 |-> on && O_PHY_TX_EN == ~$past(I_PORT_PD)) else $error("saving on");
   // first edge after a reset still shows the all-ones reset gating
   a_normal_on: assert property (
      hi && !$past(I_SRST) && O_PWR_MODE == 2'h0 && !O_INT_RST
      |-> on && O_PHY_RX_EN == ~$past(I_PORT_PD)) else $error("normal");
   a_wake_reset: assert property (
      hi && O_PWR_MODE == 2'h2 && I_HOST_ACCESS |=> O_INT_RST && O_PWR_MODE == 2'h0) else $error("wake");
   a_int_rst_len: assert property (
      $fell(O_INT_RST) |-> cnt_r == INT_RST_CYC && on) else $error("reset length");
   a_pin_down_off: assert property (
      pin_r == 8'h00 && !I_CHIP_POWER_DOWN_N |-> nb && O_PHY_TX_EN == 0 && !O_INT_RST) else $error("pin off");
   a_sleep_entry: assert property (
      $rose(O_LOW_POWER) |-> O_PWR_MODE == 2'h1 && O_PHY_TX_EN == 0) else $error("sleep");
   cover property ($fell(O_INT_RST));
   cover property ($rose(O_LOW_POWER));
   cover property (O_PWR_MODE == 2'h3 && on);
endmodule // spm_power_checker

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   localparam [7:0] RC = 8'h06;
   reg        I_REF_CLK = 1'b0;
   reg        I_SRST = 1'b1;
   reg        I_CHIP_POWER_DOWN_N = 1'b1;
   reg  [4:0] I_CABLE_ENERGY = 5'h00;
   reg        I_MODE_WR = 1'b0;
   reg  [1:0] I_MODE_WDATA = 2'h0;
   reg  [4:0] I_PORT_PD = 5'h00;
   reg  [7:0] I_SLEEP_DELAY = 8'h03;
   reg        I_HOST_ACCESS = 1'b0;
   wire       O_PLL_CLK_EN, O_MAC_EN, O_HOST_EN, O_INT_RST, O_LOW_POWER;
   wire [4:0] O_PHY_TX_EN, O_PHY_RX_EN, O_RX_ENERGY_DET_EN;
   wire [1:0] O_PWR_MODE;
   // status byte: int_rst, low_power, pll, mac, host, 0, mode
   wire [7:0] st = {O_INT_RST, O_LOW_POWER, O_PLL_CLK_EN, O_MAC_EN, O_HOST_EN, 1'b0, O_PWR_MODE};
   integer    errors = 0;
   integer    checks = 0;
   integer    cyc = 0;
   integer    n;
   always #2.5 I_REF_CLK = ~I_REF_CLK;
   spm_power_ctrl
   #(
      .SLEEP_TICK_CYC (4),
      .INT_RST_CYC    (RC)
   )
   DUT
   (
      .I_REF_CLK           (I_REF_CLK),
      .I_SRST              (I_SRST),
      .I_CHIP_POWER_DOWN_N (I_CHIP_POWER_DOWN_N),
      .I_CABLE_ENERGY      (I_CABLE_ENERGY),
      .I_MODE_WR           (I_MODE_WR),
      .I_MODE_WDATA        (I_MODE_WDATA),
      .I_PORT_PD           (I_PORT_PD),
      .I_SLEEP_DELAY       (I_SLEEP_DELAY),
      .I_HOST_ACCESS       (I_HOST_ACCESS),
      .O_PLL_CLK_EN        (O_PLL_CLK_EN),
      .O_MAC_EN            (O_MAC_EN),
      .O_HOST_EN           (O_HOST_EN),
      .O_PHY_TX_EN         (O_PHY_TX_EN),
      .O_PHY_RX_EN         (O_PHY_RX_EN),
      .O_RX_ENERGY_DET_EN  (O_RX_ENERGY_DET_EN),
      .O_PWR_MODE          (O_PWR_MODE),
      .O_INT_RST           (O_INT_RST),
      .O_LOW_POWER         (O_LOW_POWER)
   );
   task end_of_test;
   begin
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   always @(posedge I_REF_CLK)
   begin
      cyc = cyc + 1;
      if (cyc == 3000)
      begin
         errors = errors + 1;
         end_of_test;
      end
   end
   task chk(input [7:0] g, input [7:0] e);
   begin
      checks = checks + 1;
      if (g !== e)
      begin
         errors = errors + 1;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   end
   endtask
   task w(input integer k);
      repeat (k) @(posedge I_REF_CLK);
   endtask
   task wr(input [1:0] m);
   begin
      w(1);
      I_MODE_WR <= 1'b1;
      I_MODE_WDATA <= m;
      w(1);
      I_MODE_WR <= 1'b0;
      @(negedge I_REF_CLK);
   end
   endtask
   // bounded wait for internal reset, then measure its length
   task rst_len;
   begin
      n = 0;
      while (O_INT_RST !== 1'b1 && n < 20)
      begin
         @(negedge I_REF_CLK);
         n = n + 1;
      end
      n = 0;
      while (O_INT_RST === 1'b1 && n < 40)
      begin
         @(negedge I_REF_CLK);
         n = n + 1;
      end
      chk(n[7:0], RC);
      chk(st, 8'h38);
   end
   endtask
   task t_save;
   begin
      w(1);
      I_PORT_PD <= 5'h05;
      I_CABLE_ENERGY <= 5'h03;
      w(6);
      wr(2'h3);
      chk(st, 8'h3B);
      chk(O_PHY_TX_EN, 8'h1A);
      chk(O_PHY_RX_EN, 8'h02);
      wr(2'h0);
      chk(st, 8'h38);
      chk(O_PHY_RX_EN, 8'h1A);
      $display("test save done");
   end
   endtask
   task t_soft;
   begin
      wr(2'h2);
      chk(st, 8'h02);
      wr(2'h0);
      chk(st, 8'h02);
      w(1);
      I_HOST_ACCESS <= 1'b1;
      w(1);
      I_HOST_ACCESS <= 1'b0;
      @(negedge I_REF_CLK);
      chk(st, 8'h80);
      rst_len;
      $display("test soft done");
   end
   endtask
   task t_pin;
   begin
      w(1);
      I_CHIP_POWER_DOWN_N <= 1'b0;
      w(12);
      @(negedge I_REF_CLK);
      chk(st & 8'hFC, 8'h00);
      chk(O_PHY_TX_EN | O_PHY_RX_EN, 8'h00);
      w(1);
      I_CHIP_POWER_DOWN_N <= 1'b1;
      rst_len;
      $display("test pin done");
   end
   endtask
   task t_energy;
   begin
      wr(2'h1);
      chk(st, 8'h01);
      chk(O_RX_ENERGY_DET_EN, 8'h1A);
      w(1);
      I_CABLE_ENERGY <= 5'h00;
      n = 0;
      while (O_LOW_POWER !== 1'b1 && n < 60)
      begin
         @(negedge I_REF_CLK);
         n = n + 1;
      end
      // four ticks of four cycles after the filter settles
      chk((n > 19) && (n < 31), 8'h01);
      chk(O_PHY_TX_EN, 8'h00);
      w(1);
      I_CABLE_ENERGY <= 5'h10;
      w(8);
      @(negedge I_REF_CLK);
      chk(st, 8'h01);
      chk(O_PHY_TX_EN, 8'h1A);
      w(1);
      I_SRST <= 1'b1;
      w(4);
      I_SRST <= 1'b0;
      @(negedge I_REF_CLK);
      chk(st, 8'h38);
      $display("test energy done");
   end
   endtask
   initial
   begin
      w(12);
      I_SRST <= 1'b0;
      @(negedge I_REF_CLK);
      chk(st, 8'h38);
      chk(O_PHY_TX_EN, 8'h1F);
      $display("test reset done");
      t_save;
      t_soft;
      t_pin;
      t_energy;
      end_of_test;
   end
endmodule // tb_top
bind spm_power_ctrl spm_power_checker
#(
   .NUM_PORTS   (NUM_PORTS),
   .INT_RST_CYC (INT_RST_CYC)
)
u_chk
(
   .I_REF_CLK           (I_REF_CLK),
   .I_SRST              (I_SRST),
   .I_CHIP_POWER_DOWN_N (I_CHIP_POWER_DOWN_N),
   .I_MODE_WR           (I_MODE_WR),
   .I_MODE_WDATA        (I_MODE_WDATA),
   .I_PORT_PD           (I_PORT_PD),
   .I_HOST_ACCESS       (I_HOST_ACCESS),
   .O_PLL_CLK_EN        (O_PLL_CLK_EN),
   .O_MAC_EN            (O_MAC_EN),
   .O_HOST_EN           (O_HOST_EN),
   .O_PHY_TX_EN         (O_PHY_TX_EN),
   .O_PHY_RX_EN         (O_PHY_RX_EN),
   .O_PWR_MODE          (O_PWR_MODE),
   .O_INT_RST           (O_INT_RST),
   .O_LOW_POWER         (O_LOW_POWER)
);
